/* File: hdl/region_decode.sv */
`timescale 1ns/1ps
// Classifies one flash word address against the boot and fixed boundaries.
module region_decode (
    input wire logic [1:0] boot_size_fuses,
    input wire logic [spm_ctrl_pkg::ADDR_W-1:0] addr,
    output logic in_boot,
    output logic in_ncr
);
    logic [spm_ctrl_pkg::ADDR_W-1:0] boot_start;

    always_comb begin
        unique case (boot_size_fuses)
            2'h0: boot_start = spm_ctrl_pkg::BOOT_START_0;
            2'h1: boot_start = spm_ctrl_pkg::BOOT_START_1;
            2'h2: boot_start = spm_ctrl_pkg::BOOT_START_2;
            2'h3: boot_start = spm_ctrl_pkg::BOOT_START_3;
        endcase
    end

    assign in_boot = addr >= boot_start;
    assign in_ncr = addr >= spm_ctrl_pkg::NCR_START;
endmodule

/* File: hdl/self_program_section_control.sv */
`timescale 1ns/1ps
// Functional notes
// - Store refused when issued from application region.
// - Boot code may store to any page.
// - Boot size fuses split application and boot.
// - Fixed boundary splits concurrent and no-concurrent regions.
// - Concurrent-region programming never halts the CPU.
// - No-concurrent-region programming halts CPU throughout.
// - Concurrent region unreadable while being programmed.
// - Boot region always inside no-concurrent region.
// - Busy flag reads one while region blocked.
// - Classification follows store target, not read address.
// - Two independent lock sets, application and boot.
// - Lock codes: 11 free, 10 nostore, 00 both, 01 noload.
// - Locks only programmed; chip erase restores them. Here rst also reloads LOCK_RESET (11).
module self_program_section_control (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [1:0] boot_size_fuses,
    input wire logic store_valid,
    input wire spm_ctrl_pkg::store_req_s store_req,
    input wire logic load_valid,
    input wire spm_ctrl_pkg::load_req_s load_req,
    input wire logic fetch_valid,
    input wire logic [spm_ctrl_pkg::ADDR_W-1:0] fetch_addr,
    input wire logic busy_clear,
    input wire logic lock_write,
    input wire logic [1:0] application_lock_set_wdata,
    input wire logic [1:0] boot_region_lock_set_wdata,
    input wire logic chip_erase,
    output logic store_accepted_ff,
    output logic store_refused_ff,
    output logic cpu_halt_ff,
    output logic concurrent_region_busy_flag_ff,
    output logic prog_active_ff,
    output logic load_allowed_ff,
    output logic fetch_blocked_ff,
    output logic [1:0] application_lock_set_ff,
    output logic [1:0] boot_region_lock_set_ff
);
    typedef enum logic [1:0] {IDLE, PROG_CR, PROG_NCR} prog_state_e;

    prog_state_e state_ff;
    logic [spm_ctrl_pkg::CNT_W-1:0] cnt_ff;
    logic pc_boot, tgt_boot, tgt_ncr, ld_boot, ld_ncr, ldpc_boot, fe_ncr;
    logic store_ok, load_ok, done;

    region_decode u_pc (
        .boot_size_fuses(boot_size_fuses),
        .addr(store_req.pc),
        .in_boot(pc_boot),
        .in_ncr()
    );
    region_decode u_tgt (
        .boot_size_fuses(boot_size_fuses),
        .addr({store_req.target[spm_ctrl_pkg::ADDR_W-1:spm_ctrl_pkg::PAGE_W], {spm_ctrl_pkg::PAGE_W{1'b0}}}),
        .in_boot(tgt_boot),
        .in_ncr(tgt_ncr)
    );
    region_decode u_ld (
        .boot_size_fuses(boot_size_fuses),
        .addr(load_req.addr),
        .in_boot(ld_boot),
        .in_ncr(ld_ncr)
    );
    region_decode u_fe (
        .boot_size_fuses(boot_size_fuses),
        .addr(fetch_addr),
        .in_boot(),
        .in_ncr(fe_ncr)
    );
    region_decode u_ldpc (
        .boot_size_fuses(boot_size_fuses),
        .addr(load_req.pc),
        .in_boot(ldpc_boot),
        .in_ncr()
    );

    // Stores come only from boot code; the target may be any page the lock of its region permits.
    always_comb begin
        store_ok = pc_boot;
        if (tgt_boot) begin
            store_ok = store_ok && boot_region_lock_set_ff[0];
        end else begin
            store_ok = store_ok && application_lock_set_ff[0];
        end
    end

    // Cross-region loads check the lock of the region being read; bit 1 low forbids them.
    always_comb begin
        load_ok = 1'b1;
        if (ld_boot && !ldpc_boot) begin
            load_ok = boot_region_lock_set_ff[1];
        end else if (!ld_boot && ldpc_boot) begin
            load_ok = application_lock_set_ff[1];
        end
        if (state_ff == PROG_CR && !ld_ncr) begin
            load_ok = 1'b0;
        end
    end

    assign done = cnt_ff == spm_ctrl_pkg::CNT_W'(spm_ctrl_pkg::PROG_CYCLES - 1);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_ff <= IDLE;
            cnt_ff <= '0;
        end else begin
            unique case (state_ff)
                IDLE: begin
                    cnt_ff <= '0;
                    if (store_valid && store_ok) begin
                        state_ff <= tgt_ncr ? PROG_NCR : PROG_CR;
                    end
                end
                PROG_CR, PROG_NCR: begin
                    cnt_ff <= cnt_ff + 1'b1;
                    if (done) begin
                        state_ff <= IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            store_accepted_ff <= 1'b0;
            store_refused_ff <= 1'b0;
        end else begin
            store_accepted_ff <= store_valid && state_ff == IDLE && store_ok;
            store_refused_ff <= store_valid && !(state_ff == IDLE && store_ok);
        end
    end

    // Halt spans the whole operation only when the target is in the no-concurrent region.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cpu_halt_ff <= 1'b0;
            prog_active_ff <= 1'b0;
        end else if (state_ff == IDLE) begin
            cpu_halt_ff <= store_valid && store_ok && tgt_ncr;
            prog_active_ff <= store_valid && store_ok;
        end else if (done) begin
            cpu_halt_ff <= 1'b0;
            prog_active_ff <= 1'b0;
        end
    end

    // Busy stays set after completion until software clears it; a new start wins over a clear.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            concurrent_region_busy_flag_ff <= 1'b0;
        end else if (state_ff == IDLE && store_valid && store_ok && !tgt_ncr) begin
            concurrent_region_busy_flag_ff <= 1'b1;
        end else if (busy_clear && state_ff != PROG_CR) begin
            concurrent_region_busy_flag_ff <= 1'b0;
        end
    end

    // While busy, the concurrent region stays blocked for both fetch and load.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            load_allowed_ff <= 1'b0;
            fetch_blocked_ff <= 1'b0;
        end else begin
            load_allowed_ff <= load_valid && load_ok && !(concurrent_region_busy_flag_ff && !ld_ncr);
            fetch_blocked_ff <= fetch_valid && ((concurrent_region_busy_flag_ff && !fe_ncr) || cpu_halt_ff);
        end
    end

    // Lock bits can only be driven toward zero; chip erase and reset restore ones.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            application_lock_set_ff <= spm_ctrl_pkg::LOCK_RESET;
            boot_region_lock_set_ff <= spm_ctrl_pkg::LOCK_RESET;
        end else if (chip_erase) begin
            application_lock_set_ff <= spm_ctrl_pkg::LOCK_NONE;
            boot_region_lock_set_ff <= spm_ctrl_pkg::LOCK_NONE;
        end else if (lock_write) begin
            application_lock_set_ff <= application_lock_set_ff & application_lock_set_wdata;
            boot_region_lock_set_ff <= boot_region_lock_set_ff & boot_region_lock_set_wdata;
        end
    end

    region_layout_a: assert property (@(posedge core_clk) disable iff (rst)
        tgt_boot |-> tgt_ncr) else $error("boot region outside no-concurrent region");
    app_store_refused_a: assert property (@(posedge core_clk) disable iff (rst)
        store_valid && !pc_boot |=> store_refused_ff && !store_accepted_ff) else $error("store from application taken");
    ncr_halt_a: assert property (@(posedge core_clk) disable iff (rst)
        state_ff == IDLE && store_valid && store_ok && tgt_ncr |=> cpu_halt_ff [*8]) else $error("halt not held");
    cr_no_halt_a: assert property (@(posedge core_clk) disable iff (rst)
        state_ff == PROG_CR |-> !cpu_halt_ff) else $error("CPU halted for concurrent target");
    busy_set_a: assert property (@(posedge core_clk) disable iff (rst)
        state_ff == PROG_CR |-> concurrent_region_busy_flag_ff) else $error("busy low while blocked");
    busy_sticky_a: assert property (@(posedge core_clk) disable iff (rst)
        $fell(prog_active_ff) && !cpu_halt_ff && $past(state_ff == PROG_CR) |-> concurrent_region_busy_flag_ff)
        else $error("busy cleared by hardware");
    cr_load_block_a: assert property (@(posedge core_clk) disable iff (rst)
        load_valid && state_ff == PROG_CR && !ld_ncr |=> !load_allowed_ff) else $error("load from busy region");
    lock_monotone_a: assert property (@(posedge core_clk) disable iff (rst)
        !$past(chip_erase) && !$past(rst) |-> (application_lock_set_ff & ~$past(application_lock_set_ff)) == 2'h0)
        else $error("lock bit returned to one");
    op_length_a: assert property (@(posedge core_clk) disable iff (rst)
        $rose(prog_active_ff) |-> prog_active_ff [*8]) else $error("operation too short");
    boot_lock_monotone_a: assert property (@(posedge core_clk) disable iff (rst)
        !$past(chip_erase) && !$past(rst) |-> (boot_region_lock_set_ff & ~$past(boot_region_lock_set_ff)) == 2'h0)
        else $error("boot lock bit returned to one");
    halt_fetch_block_a: assert property (@(posedge core_clk) disable iff (rst)
        fetch_valid && cpu_halt_ff |=> fetch_blocked_ff) else $error("fetch served while halted");
    cr_fetch_block_a: assert property (@(posedge core_clk) disable iff (rst)
        fetch_valid && state_ff == PROG_CR && !fe_ncr |=> fetch_blocked_ff) else $error("fetch from busy region");
    locked_store_refused_a: assert property (@(posedge core_clk) disable iff (rst)
        store_valid && !tgt_boot && !application_lock_set_ff[0] |=> store_refused_ff) else $error("locked store taken");
    boot_store_taken_a: assert property (@(posedge core_clk) disable iff (rst)
        store_valid && state_ff == IDLE && pc_boot && (tgt_boot ? boot_region_lock_set_ff[0] : application_lock_set_ff[0])
        |=> store_accepted_ff && prog_active_ff) else $error("boot store not started");
endmodule

/* File: hdl/spm_ctrl_pkg.sv */
package spm_ctrl_pkg;
    // Flash word address width: 128K bytes as 64K words.
    localparam int ADDR_W = 16;
    localparam int PAGE_W = 7;
    // Fixed concurrent-read boundary: words at or above it are no-concurrent-read.
    localparam logic [ADDR_W-1:0] NCR_START = 16'hF000;
    // Boot region start for each boot size setting; all lie at or above NCR_START.
    localparam logic [ADDR_W-1:0] BOOT_START_0 = 16'hF000;
    localparam logic [ADDR_W-1:0] BOOT_START_1 = 16'hF800;
    localparam logic [ADDR_W-1:0] BOOT_START_2 = 16'hFC00;
    localparam logic [ADDR_W-1:0] BOOT_START_3 = 16'hFE00;
    // Lock set encodings, one means unprogrammed.
    localparam logic [1:0] LOCK_NONE = 2'h3;
    localparam logic [1:0] LOCK_NO_STORE = 2'h2;
    localparam logic [1:0] LOCK_ALL = 2'h0;
    localparam logic [1:0] LOCK_NO_LOAD = 2'h1;
    localparam logic [1:0] LOCK_RESET = 2'h3;
    // Time a page erase or write keeps the array busy.
    localparam int PROG_TIME_US = 4;
    localparam int CLK_MHZ = 100;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    localparam int CNT_W = 9;

    typedef struct packed {
        logic [ADDR_W-1:0] target;
        logic [ADDR_W-1:0] pc;
        logic erase;
    } store_req_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [ADDR_W-1:0] pc;
    } load_req_s;
endpackage

/* File: verif/cpu_core_model.sv */
`timescale 1ns/1ps
module cpu_core_model (
    input wire logic core_clk,
    output logic store_valid,
    output spm_ctrl_pkg::store_req_s store_req,
    output logic load_valid,
    output spm_ctrl_pkg::load_req_s load_req,
    output logic fetch_valid,
    output logic [spm_ctrl_pkg::ADDR_W-1:0] fetch_addr,
    output logic busy_clear
);
    initial begin
        store_valid = 1'b0;
        store_req = '0;
        load_valid = 1'b0;
        load_req = '0;
        fetch_valid = 1'b0;
        fetch_addr = '0;
        busy_clear = 1'b0;
    end
    // Requests are one-cycle pulses; payloads are inverted afterwards so no stale value can be relied upon.
    task automatic store(input logic [15:0] target, input logic [15:0] pc);
        @(negedge core_clk);
        store_req = '{target: target, pc: pc, erase: 1'b1};
        store_valid = 1'b1;
        @(negedge core_clk);
        store_valid = 1'b0;
        store_req = ~store_req;
    endtask
    task automatic load(input logic [15:0] addr, input logic [15:0] pc);
        @(negedge core_clk);
        load_req = '{addr: addr, pc: pc};
        load_valid = 1'b1;
        @(negedge core_clk);
        load_valid = 1'b0;
        load_req = ~load_req;
    endtask
    // A concurrent-region fetch while busy is only issued when the bench asks for it on purpose.
    task automatic fetch(input logic [15:0] addr);
        @(negedge core_clk);
        fetch_addr = addr;
        fetch_valid = 1'b1;
        @(negedge core_clk);
        fetch_valid = 1'b0;
        fetch_addr = ~fetch_addr;
    endtask
    task automatic clear_busy();
        @(negedge core_clk);
        busy_clear = 1'b1;
        @(negedge core_clk);
        busy_clear = 1'b0;
    endtask
endmodule

/* File: verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic core_clk, rst, lock_write, chip_erase, store_valid, load_valid, fetch_valid, busy_clear;
    logic [1:0] boot_size_fuses, app_wd, boot_wd, app_lock, boot_lock;
    logic acc, refused, halt, busy, active, load_ok, blocked;
    logic [15:0] fetch_addr;
    spm_ctrl_pkg::store_req_s store_req;
    spm_ctrl_pkg::load_req_s load_req;
    logic [15:0] starts [4];
    int failures = 0;
    int samples_checked = 0;
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    cpu_core_model u_cpu (.core_clk(core_clk), .store_valid(store_valid), .store_req(store_req),
        .load_valid(load_valid), .load_req(load_req), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
        .busy_clear(busy_clear));
    self_program_section_control u_dut (.core_clk(core_clk), .rst(rst), .boot_size_fuses(boot_size_fuses),
        .store_valid(store_valid), .store_req(store_req), .load_valid(load_valid), .load_req(load_req),
        .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .busy_clear(busy_clear), .lock_write(lock_write),
        .application_lock_set_wdata(app_wd), .boot_region_lock_set_wdata(boot_wd), .chip_erase(chip_erase),
        .store_accepted_ff(acc), .store_refused_ff(refused), .cpu_halt_ff(halt),
        .concurrent_region_busy_flag_ff(busy), .prog_active_ff(active), .load_allowed_ff(load_ok),
        .fetch_blocked_ff(blocked), .application_lock_set_ff(app_lock), .boot_region_lock_set_ff(boot_lock));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checked %0d values, %0d mismatches", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic store(input logic [15:0] t, input logic [15:0] pc, input logic exp_acc);
        u_cpu.store(t, pc);
        check({acc, refused}, {exp_acc, ~exp_acc});
    endtask
    task automatic wait_done(input int exp_n, input logic exp_halt);
        int n;
        n = 0;
        while (active === 1'b1 && n < 1000) begin
            check(halt, exp_halt);
            n++;
            @(negedge core_clk);
        end
        check(n, exp_n);
        check(halt, 1'b0);
        u_cpu.clear_busy();
        check(busy, 1'b0);
    endtask
    task automatic locks(input logic [1:0] a, input logic [1:0] b, input logic erase);
        @(negedge core_clk);
        {lock_write, app_wd, boot_wd, chip_erase} = {~erase, a, b, erase};
        @(negedge core_clk);
        {lock_write, chip_erase} = 2'b00;
    endtask
    initial begin
        #100000;
        failures++;
        print_verdict();
    end
    initial begin
        starts = '{spm_ctrl_pkg::BOOT_START_0, spm_ctrl_pkg::BOOT_START_1, spm_ctrl_pkg::BOOT_START_2,
                   spm_ctrl_pkg::BOOT_START_3};
        {rst, lock_write, chip_erase, app_wd, boot_wd, boot_size_fuses} = {3'b100, 2'h3, 2'h3, 2'h0};
        repeat (5) @(negedge core_clk);
        rst = 1'b0;
        check({app_lock, boot_lock, acc, active, busy}, {4'hF, 3'b000});
        $display("test reset done");
        // Every fuse code: the word just below the boot start is application code and may not store.
        for (int i = 0; i < 4; i++) begin
            boot_size_fuses = 2'(i);
            store(16'h0200, starts[i] - 16'h0001, 1'b0);
            store(16'h0200, starts[i], 1'b1);
            check({halt, busy}, 2'b01);
            wait_done(spm_ctrl_pkg::PROG_CYCLES, 1'b0);
        end
        $display("test fuse table done");
        boot_size_fuses = 2'h0;
        store(16'h0200, 16'hF000, 1'b1);
        u_cpu.fetch(16'hF100);
        check(blocked, 1'b0);
        u_cpu.fetch(16'h0100);
        check(blocked, 1'b1);
        u_cpu.load(16'h0100, 16'hF000);
        check(load_ok, 1'b0);
        u_cpu.load(16'hF100, 16'hF000);
        check(load_ok, 1'b1);
        u_cpu.clear_busy();
        check(busy, 1'b1);
        store(16'h0300, 16'hF000, 1'b0);
        wait_done(spm_ctrl_pkg::PROG_CYCLES - 12, 1'b0);
        $display("test concurrent op done");
        store(16'hEFFF, 16'hF000, 1'b1);
        wait_done(spm_ctrl_pkg::PROG_CYCLES, 1'b0);
        store(16'hF000, 16'hF000, 1'b1);
        u_cpu.fetch(16'hF100);
        check(blocked, 1'b1);
        wait_done(spm_ctrl_pkg::PROG_CYCLES - 2, 1'b1);
        $display("test boundary done");
        locks(2'h2, 2'h3, 1'b0);
        check(app_lock, 2'h2);
        store(16'h0200, 16'hF000, 1'b0);
        store(16'hF800, 16'hF000, 1'b1);
        wait_done(spm_ctrl_pkg::PROG_CYCLES, 1'b1);
        locks(2'h3, 2'h3, 1'b0);
        check(app_lock, 2'h2);
        u_cpu.load(16'h0100, 16'hF000);
        check(load_ok, 1'b1);
        locks(2'h1, 2'h0, 1'b0);
        check({app_lock, boot_lock}, 4'h0);
        u_cpu.load(16'h0100, 16'hF000);
        check(load_ok, 1'b0);
        u_cpu.load(16'hF800, 16'h0100);
        check(load_ok, 1'b0);
        store(16'hF800, 16'hF000, 1'b0);
        locks(2'h3, 2'h3, 1'b1);
        check({app_lock, boot_lock}, 4'hF);
        u_cpu.load(16'h0100, 16'hF000);
        check(load_ok, 1'b1);
        $display("test locks done");
        print_verdict();
    end
endmodule
